// ===== image_sensor_readout_sequencer.v
// register file and readout sequencer of the image sensor
// Contract
// - sequencer control bit 0 picks global (0) or rolling (1) shutter.
// - amplifier is calibrated each row blank; mode 0 full, mode 1 incremental.
// - frame cal mode on first row after frame begin; row mode after.
// - column shifter runs at half rate; odd/even buses merged at full rate.
// - snapshot clock period 32/64/128/256 clocks from bits 7:6.
// - row sequencer clock period 4/8/16/32 clocks from bits 5:4.
// - multislope bit 10 selects right-side reset with knee level.
// - row window rises on row sync, falls at pixel count limit.
// - line counter counts row advances; final row pulse at line limit.
// - global mode counts snapshot clocks to exposure count, pulses done.
// - rolling frame begin loads read pointer; row advance shifts, counts.
// - rolling exposure match issues reset pointer sync, loads start.
// - read pointer sync clears exposure counter; pointers keep advancing.
// - 640 column start positions; sub-sampling allows only even ones.
// - 1024 row starts for read and reset pointers, kept equal.
// - array bits 1:0 test mode; bit0 even, bit1 odd columns to reset.
// - column sub-sampling from bits 4:2, row sub-sampling from 7:5.
// - gain code bits 3:0 used only while bypass bit is 0.
// - amplifier active bit 0 puts whole amplifier in standby.
// - all configuration registers clear to zero at reset.
// - 16-bit write word: bits 15:12 register select, 11:0 data.
`timescale 1ns/1ps
`include "sensor_seq_defines.vh"
module image_sensor_readout_sequencer #(
  parameter CFG_W   = 12,
  parameter PTR_W   = 11,
  parameter PIX_W   = 10
) (
  input  wire             SYS_CLK_IN,
  input  wire             RESET_N_IN,
  input  wire [15:0]      CFG_WORD_IN,
  input  wire             CFG_WRITE_IN,
  input  wire             FRAME_BEGIN_IN,
  input  wire             ROW_ADVANCE_IN,
  input  wire             SNAP_BEGIN_IN,
  input  wire             SNAP_END_IN,
  input  wire [PIX_W-1:0] EVEN_BUS_IN,
  input  wire [PIX_W-1:0] ODD_BUS_IN,
  input  wire             PIX_READY_IN,
  output wire             PIX_VALID_OUT,
  output wire [PIX_W-1:0] PIX_DATA_OUT,
  output wire             ROLLING_MODE_OUT,
  output reg              CAL_ACTIVE_OUT,
  output reg              CAL_SLOW_OUT,
  output reg              COL_SHIFT_CLK_OUT,
  output reg              ROW_WINDOW_OUT,
  output reg              FINAL_ROW_OUT,
  output reg              EXPOSURE_DONE_OUT,
  output reg              READ_SYNC_OUT,
  output reg              RESET_SYNC_OUT,
  output reg  [PTR_W-1:0] READ_ROW_OUT,
  output reg  [PTR_W-1:0] RESET_ROW_OUT,
  output reg  [PTR_W-1:0] COL_ADDR_OUT,
  output wire             RESET_RIGHT_OUT,
  output wire [1:0]       KNEE_LEVEL_OUT,
  output wire             CONT_CHARGE_OUT,
  output wire             EXT_VDDR_OUT,
  output wire             TEST_EVEN_OUT,
  output wire             TEST_ODD_OUT,
  output wire [2:0]       COL_SUB_OUT,
  output wire [2:0]       ROW_SUB_OUT,
  output wire [3:0]       AMP_GAIN_OUT,
  output wire             AMP_UNITY_OUT,
  output wire             AMP_DUAL_OUT,
  output wire             AMP_STANDBY_OUT
);

  // configuration registers
  reg [CFG_W-1:0] seq_ctrl_q;
  reg [CFG_W-1:0] pix_limit_q;
  reg [CFG_W-1:0] line_limit_q;
  reg [CFG_W-1:0] exposure_q;
  reg [PTR_W-1:0] col_start_q;
  reg [PTR_W-1:0] read_start_q;
  reg [PTR_W-1:0] reset_start_q;
  reg [7:0]       array_ctrl_q;
  reg [6:0]       amp_ctrl_q;

  wire [3:0]       wr_sel;
  wire [CFG_W-1:0] wr_data;

  // whole word decoded in the write cycle
  assign wr_sel  = CFG_WORD_IN[`WORD_ADDR_MSB:`WORD_ADDR_LSB];
  assign wr_data = CFG_WORD_IN[`WORD_DATA_MSB:0];

  // writes; unlisted selects are ignored
  always @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      seq_ctrl_q    <= `CFG_RESET_VALUE;
      pix_limit_q   <= `CFG_RESET_VALUE;
      line_limit_q  <= `CFG_RESET_VALUE;
      exposure_q    <= `CFG_RESET_VALUE;
      col_start_q   <= `PTR_RESET_VALUE;
      read_start_q  <= `PTR_RESET_VALUE;
      reset_start_q <= `PTR_RESET_VALUE;
      array_ctrl_q  <= 8'h00;
      amp_ctrl_q    <= 7'h00;
    end else if (CFG_WRITE_IN) begin
      case (wr_sel)
        `REG_SEQ_CTRL:    seq_ctrl_q    <= wr_data;
        `REG_PIX_LIMIT:   pix_limit_q   <= wr_data;
        `REG_LINE_LIMIT:  line_limit_q  <= wr_data;
        `REG_EXPOSURE:    exposure_q    <= wr_data;
        `REG_COL_START:   col_start_q   <= wr_data[PTR_W-1:0];
        `REG_READ_START:  read_start_q  <= wr_data[PTR_W-1:0];
        `REG_RESET_START: reset_start_q <= wr_data[PTR_W-1:0];
        `REG_ARRAY_CTRL:  array_ctrl_q  <= wr_data[7:0];
        `REG_AMP_CTRL:    amp_ctrl_q    <= wr_data[6:0];
        default:          ;
      endcase
    end
  end

  // static field decode
  wire rolling = seq_ctrl_q[`SEQ_SHUTTER_BIT];
  assign ROLLING_MODE_OUT = rolling;
  assign RESET_RIGHT_OUT  = seq_ctrl_q[`SEQ_MSLOPE_BIT];
  // knee level only reaches the right-side circuit
  assign KNEE_LEVEL_OUT   = seq_ctrl_q[`SEQ_MSLOPE_BIT] ?
                            seq_ctrl_q[`SEQ_KNEE_LSB+1:`SEQ_KNEE_LSB] :
                            2'b00;
  assign CONT_CHARGE_OUT  = seq_ctrl_q[`SEQ_CONT_CHG_BIT];
  assign EXT_VDDR_OUT     = seq_ctrl_q[`SEQ_EXT_VDDR_BIT];
  assign TEST_EVEN_OUT    = array_ctrl_q[`ARR_TEST_LSB];
  assign TEST_ODD_OUT     = array_ctrl_q[`ARR_TEST_LSB+1];
  assign COL_SUB_OUT      = array_ctrl_q[`ARR_COL_SUB_LSB+2:
                                         `ARR_COL_SUB_LSB];
  assign ROW_SUB_OUT      = array_ctrl_q[`ARR_ROW_SUB_LSB+2:
                                         `ARR_ROW_SUB_LSB];
  // bypass forces the code to zero so unity feedback wins
  assign AMP_UNITY_OUT    = amp_ctrl_q[`AMP_BYPASS_BIT];
  assign AMP_GAIN_OUT     = amp_ctrl_q[`AMP_BYPASS_BIT] ? 4'h0 :
                            amp_ctrl_q[`AMP_GAIN_LSB+3:`AMP_GAIN_LSB];
  assign AMP_STANDBY_OUT  = ~amp_ctrl_q[`AMP_ACTIVE_BIT];
  assign AMP_DUAL_OUT     = amp_ctrl_q[`AMP_DUAL_BIT] &
                            amp_ctrl_q[`AMP_ACTIVE_BIT];

  // period from base and 2-bit code
  function [8:0] div_period;
    input [8:0] base;
    input [1:0] code;
    begin
      div_period = base << code;
    end
  endfunction

  wire snap_tick;
  wire row_tick;

  // snapshot clock realigned at snapshot begin
  clock_granule #(.WIDTH(9)) snap_div (
    .clk_in     (SYS_CLK_IN),
    .reset_n_in (RESET_N_IN),
    .restart_in (SNAP_BEGIN_IN),
    .period_in  (div_period(`SNAP_DIV_BASE,
                            seq_ctrl_q[`SEQ_SNAP_DIV_LSB+1:
                                       `SEQ_SNAP_DIV_LSB])),
    .tick_out   (snap_tick)
  );

  // row clock realigned at each row advance
  clock_granule #(.WIDTH(9)) row_div (
    .clk_in     (SYS_CLK_IN),
    .reset_n_in (RESET_N_IN),
    .restart_in (ROW_ADVANCE_IN),
    .period_in  (div_period(`ROW_DIV_BASE,
                            seq_ctrl_q[`SEQ_ROW_DIV_LSB+1:
                                       `SEQ_ROW_DIV_LSB])),
    .tick_out   (row_tick)
  );

  // row blanking: calibrate, then one row clock later start the row sync
  reg first_row_q;
  reg blank_q;
  reg row_sync_q;
  always @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      first_row_q    <= 1'b0;
      blank_q        <= 1'b0;
      row_sync_q     <= 1'b0;
      CAL_ACTIVE_OUT <= 1'b0;
      CAL_SLOW_OUT   <= 1'b0;
    end else begin
      row_sync_q <= 1'b0;
      if (FRAME_BEGIN_IN)
        first_row_q <= 1'b1;
      if (ROW_ADVANCE_IN) begin
        blank_q        <= 1'b1;
        CAL_ACTIVE_OUT <= 1'b1;
        // first row of frame uses frame mode, later rows the row mode
        CAL_SLOW_OUT   <= (first_row_q | FRAME_BEGIN_IN) ?
                          seq_ctrl_q[`SEQ_FRAME_CAL_BIT] :
                          seq_ctrl_q[`SEQ_ROW_CAL_BIT];
        first_row_q    <= 1'b0;
      end else if (blank_q && row_tick) begin
        blank_q        <= 1'b0;
        CAL_ACTIVE_OUT <= 1'b0;
        row_sync_q     <= 1'b1;
      end
    end
  end

  // column shifter at half rate, pixel counter per pair
  reg [CFG_W-1:0] pix_cnt_q;
  reg             phase_q;
  reg             buf_wr;
  reg [PIX_W-1:0] buf_wdata;
  wire            buf_ready;
  always @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      pix_cnt_q         <= 12'h000;
      phase_q           <= 1'b0;
      ROW_WINDOW_OUT    <= 1'b0;
      COL_SHIFT_CLK_OUT <= 1'b0;
      COL_ADDR_OUT      <= 11'h000;
    end else if (row_sync_q) begin
      // odd start is forced even while sub-sampling
      COL_ADDR_OUT      <= (array_ctrl_q[`ARR_COL_SUB_LSB]) ?
                           {col_start_q[PTR_W-1:1], 1'b0} : col_start_q;
      pix_cnt_q         <= 12'h000;
      phase_q           <= 1'b0;
      ROW_WINDOW_OUT    <= 1'b1;
      COL_SHIFT_CLK_OUT <= 1'b0;
    end else if (ROW_WINDOW_OUT && buf_ready) begin
      // stall on a full buffer so no word is lost
      phase_q           <= ~phase_q;
      COL_SHIFT_CLK_OUT <= ~phase_q;
      if (phase_q) begin
        COL_ADDR_OUT <= COL_ADDR_OUT + 11'h001;
        if (pix_cnt_q == pix_limit_q)
          ROW_WINDOW_OUT <= 1'b0;
        else
          pix_cnt_q <= pix_cnt_q + 12'h001;
      end
    end
  end

  // merge: even bus on phase 0, odd bus on phase 1
  always @* begin
    buf_wr    = ROW_WINDOW_OUT & ~row_sync_q;
    buf_wdata = phase_q ? ODD_BUS_IN : EVEN_BUS_IN;
  end

  // two-entry output buffer
  reg [PIX_W-1:0] slot_q [0:1];
  reg             wp_q;
  reg             rp_q;
  reg [1:0]       fill_q;
  wire            push;
  wire            pop;
  assign buf_ready     = (fill_q != 2'd2);
  assign PIX_VALID_OUT = (fill_q != 2'd0);
  assign PIX_DATA_OUT  = slot_q[rp_q];
  assign push          = buf_wr & buf_ready;
  assign pop           = PIX_VALID_OUT & PIX_READY_IN;
  always @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      wp_q      <= 1'b0;
      rp_q      <= 1'b0;
      fill_q    <= 2'd0;
      slot_q[0] <= {PIX_W{1'b0}};
      slot_q[1] <= {PIX_W{1'b0}};
    end else begin
      if (push) begin
        slot_q[wp_q] <= buf_wdata;
        wp_q         <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        fill_q <= fill_q + 2'd1;
      else if (pop && !push)
        fill_q <= fill_q - 2'd1;
    end
  end

  // line counter and final row pulse
  reg [CFG_W-1:0] line_cnt_q;
  reg             lines_on_q;
  always @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      line_cnt_q    <= 12'h000;
      lines_on_q    <= 1'b0;
      FINAL_ROW_OUT <= 1'b0;
    end else begin
      FINAL_ROW_OUT <= 1'b0;
      if (FRAME_BEGIN_IN) begin
        line_cnt_q <= 12'h000;
        lines_on_q <= 1'b1;
      end else if (lines_on_q && ROW_ADVANCE_IN) begin
        if (line_cnt_q == line_limit_q) begin
          FINAL_ROW_OUT <= 1'b1;
          lines_on_q    <= 1'b0;
        end else
          line_cnt_q <= line_cnt_q + 12'h001;
      end
    end
  end

  // global shutter exposure timer
  reg [CFG_W-1:0] snap_cnt_q;
  reg             snap_on_q;
  always @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      snap_cnt_q        <= 12'h000;
      snap_on_q         <= 1'b0;
      EXPOSURE_DONE_OUT <= 1'b0;
    end else if (SNAP_BEGIN_IN && !rolling) begin
      snap_cnt_q        <= 12'h000;
      snap_on_q         <= 1'b1;
      EXPOSURE_DONE_OUT <= 1'b0;
    end else if (SNAP_END_IN || rolling) begin
      // end from outside may come early, from its own counter
      snap_on_q         <= 1'b0;
      EXPOSURE_DONE_OUT <= 1'b0;
    end else if (snap_tick) begin
      // done stands for one snapshot clock period
      EXPOSURE_DONE_OUT <= 1'b0;
      if (snap_on_q) begin
        if (snap_cnt_q + 12'h001 == exposure_q) begin
          EXPOSURE_DONE_OUT <= 1'b1;
          snap_on_q         <= 1'b0;
        end
        snap_cnt_q <= snap_cnt_q + 12'h001;
      end
    end
  end

  // rolling shutter pointers and exposure counter
  reg [CFG_W-1:0] roll_cnt_q;
  always @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      roll_cnt_q     <= 12'h000;
      READ_SYNC_OUT  <= 1'b0;
      RESET_SYNC_OUT <= 1'b0;
      READ_ROW_OUT   <= 11'h000;
      RESET_ROW_OUT  <= 11'h000;
    end else begin
      READ_SYNC_OUT  <= 1'b0;
      RESET_SYNC_OUT <= 1'b0;
      if (FRAME_BEGIN_IN) begin
        READ_SYNC_OUT <= 1'b1;
        READ_ROW_OUT  <= read_start_q;
        roll_cnt_q    <= 12'h000;
      end else if (ROW_ADVANCE_IN) begin
        READ_ROW_OUT <= READ_ROW_OUT + 11'h001;
        roll_cnt_q   <= roll_cnt_q + 12'h001;
      end
      // reset pointer keeps moving until its own sync
      if (rolling && ROW_ADVANCE_IN && !FRAME_BEGIN_IN &&
          roll_cnt_q + 12'h001 == exposure_q) begin
        RESET_SYNC_OUT <= 1'b1;
        RESET_ROW_OUT  <= reset_start_q;
      end else if (ROW_ADVANCE_IN)
        RESET_ROW_OUT <= RESET_ROW_OUT + 11'h001;
    end
  end

endmodule

// ===== sensor_seq_defines.vh
// constants for the image sensor readout sequencer
`ifndef SENSOR_SEQ_DEFINES_VH
`define SENSOR_SEQ_DEFINES_VH

// register select codes carried in word bits 15:12
`define REG_SEQ_CTRL      4'h0
`define REG_PIX_LIMIT     4'h1
`define REG_LINE_LIMIT    4'h2
`define REG_EXPOSURE      4'h3
`define REG_COL_START     4'h4
`define REG_READ_START    4'h5
`define REG_RESET_START   4'h6
`define REG_ARRAY_CTRL    4'h7
`define REG_AMP_CTRL      4'h8

// register word layout
`define WORD_ADDR_MSB     15
`define WORD_ADDR_LSB     12
`define WORD_DATA_MSB     11

// sequencer control fields
`define SEQ_SHUTTER_BIT   0
`define SEQ_FRAME_CAL_BIT 1
`define SEQ_ROW_CAL_BIT   2
`define SEQ_CONT_CHG_BIT  3
`define SEQ_ROW_DIV_LSB   4
`define SEQ_SNAP_DIV_LSB  6
`define SEQ_KNEE_LSB      8
`define SEQ_MSLOPE_BIT    10
`define SEQ_EXT_VDDR_BIT  11

// pixel array control fields
`define ARR_TEST_LSB      0
`define ARR_COL_SUB_LSB   2
`define ARR_ROW_SUB_LSB   5

// amplifier control fields
`define AMP_GAIN_LSB      0
`define AMP_BYPASS_BIT    4
`define AMP_DUAL_BIT      5
`define AMP_ACTIVE_BIT    6

// reset value of the limit, control and pointer registers; array and amplifier control use literal zeros
`define CFG_RESET_VALUE   12'h000
`define PTR_RESET_VALUE   11'h000

// divider periods in system clocks: base << code
`define SNAP_DIV_BASE     9'h020
`define ROW_DIV_BASE      9'h004

`endif

// ===== clock_granule.v
// programmable period divider producing a one-cycle tick
`timescale 1ns/1ps
module clock_granule #(
  parameter WIDTH = 9
) (
  input  wire             clk_in,
  input  wire             reset_n_in,
  input  wire             restart_in,
  input  wire [WIDTH-1:0] period_in,
  output reg              tick_out
);

  reg [WIDTH-1:0] count_q;
  wire            wrap;

  // wrap on the last system clock of each period; the registered tick follows one clock later
  assign wrap = (count_q >= period_in - {{(WIDTH-1){1'b0}}, 1'b1});

  // restart realigns the grid to an external event
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      count_q  <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else if (restart_in) begin
      count_q  <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= wrap;
      count_q  <= wrap ? {WIDTH{1'b0}} : count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ===== seq_chk_asserts.sv
// port-level assertions for the readout sequencer
`timescale 1ns/1ps
module seq_chk #(
  parameter PIX_W = 10
) (
  input logic             SYS_CLK_IN,
  input logic             RESET_N_IN,
  input logic [15:0]      CFG_WORD_IN,
  input logic             CFG_WRITE_IN,
  input logic             FRAME_BEGIN_IN,
  input logic             ROW_ADVANCE_IN,
  input logic             PIX_READY_IN,
  input logic             PIX_VALID_OUT,
  input logic [PIX_W-1:0] PIX_DATA_OUT,
  input logic             ROLLING_MODE_OUT,
  input logic             CAL_ACTIVE_OUT,
  input logic             COL_SHIFT_CLK_OUT,
  input logic             ROW_WINDOW_OUT,
  input logic             EXPOSURE_DONE_OUT,
  input logic             READ_SYNC_OUT,
  input logic             RESET_SYNC_OUT,
  input logic             RESET_RIGHT_OUT,
  input logic [1:0]       KNEE_LEVEL_OUT,
  input logic             TEST_EVEN_OUT,
  input logic             TEST_ODD_OUT,
  input logic [2:0]       COL_SUB_OUT,
  input logic [2:0]       ROW_SUB_OUT,
  input logic [3:0]       AMP_GAIN_OUT,
  input logic             AMP_STANDBY_OUT
);
  // write decode shared by the register checks
  wire [3:0]  sel = CFG_WORD_IN[15:12];
  wire [11:0] d   = CFG_WORD_IN[11:0];
  wire        wr  = CFG_WRITE_IN;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_shutter_select:
    assert property (wr && sel == 4'h0 |=> ROLLING_MODE_OUT == $past(d[0]))
    else $error("shutter select not applied");
  a_knee_route:
    assert property (wr && sel == 4'h0 |=> RESET_RIGHT_OUT == $past(d[10])
      && KNEE_LEVEL_OUT == ($past(d[10]) ? $past(d[9:8]) : 2'h0))
    else $error("reset side or knee level wrong");
  a_array_fields:
    assert property (wr && sel == 4'h7 |=> {ROW_SUB_OUT, COL_SUB_OUT,
      TEST_ODD_OUT, TEST_EVEN_OUT} == $past(d[7:0]))
    else $error("array control fields wrong");
  a_gain_bypass:
    assert property (wr && sel == 4'h8 |=>
      AMP_GAIN_OUT == ($past(d[4]) ? 4'h0 : $past(d[3:0])))
    else $error("gain code wrong");
  a_amp_standby:
    assert property (wr && sel == 4'h8 |=> AMP_STANDBY_OUT == !$past(d[6]))
    else $error("standby not applied");
  a_read_sync:
    assert property (ROLLING_MODE_OUT && FRAME_BEGIN_IN |=> READ_SYNC_OUT)
    else $error("no read sync after frame begin");
  a_cal_start:
    assert property (ROW_ADVANCE_IN |=> CAL_ACTIVE_OUT)
    else $error("no calibration after row advance");
  a_blank_min:
    assert property (ROW_ADVANCE_IN && !ROW_WINDOW_OUT |=>
      !ROW_WINDOW_OUT [*3])
    else $error("row blanking too short");
  a_pix_hold:
    assert property (PIX_VALID_OUT && !PIX_READY_IN |=>
      PIX_VALID_OUT && $stable(PIX_DATA_OUT))
    else $error("pixel lost during stall");
  a_shift_window:
    assert property (COL_SHIFT_CLK_OUT |-> ROW_WINDOW_OUT)
    else $error("column shift outside row window");
  a_done_global:
    assert property (EXPOSURE_DONE_OUT |-> !ROLLING_MODE_OUT)
    else $error("exposure done in rolling mode");
  a_reset_sync:
    assert property (RESET_SYNC_OUT |-> ROLLING_MODE_OUT)
    else $error("reset sync in global mode");

  // main scenarios reached
  c_done: cover property (EXPOSURE_DONE_OUT);
  c_rsync: cover property (RESET_SYNC_OUT);
  c_stall: cover property (PIX_VALID_OUT && !PIX_READY_IN);
endmodule

bind image_sensor_readout_sequencer seq_chk #(.PIX_W(PIX_W)) chk (.*);

// ===== timing_ctrl_model.sv
// external timing controller model making the control pulses
`timescale 1ns/1ps
module timing_ctrl_model (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire [2:0] req_in,
  input  wire done_in,
  output reg  frame_out,
  output reg  row_out,
  output reg  snap_begin_out,
  output reg  snap_end_out
);
  reg done_q;
  // one-cycle pulses launched on request
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      {frame_out, row_out, snap_begin_out, snap_end_out, done_q} <= 5'h00;
    end else begin
      frame_out      <= req_in[0];
      row_out        <= req_in[1];
      snap_begin_out <= req_in[2];
      done_q         <= done_in;
      // stop taken from done; tying them would stall the sequencer
      snap_end_out   <= done_in && !done_q;
    end
  end
endmodule

// ===== image_sensor_readout_sequencer_test.sv
// self-checking bench for the readout sequencer
`timescale 1ns/1ps
module image_sensor_readout_sequencer_test;
  reg SYS_CLK_IN = 0, RESET_N_IN = 0, CFG_WRITE_IN = 0, PIX_READY_IN = 0;
  reg [15:0] CFG_WORD_IN = 16'h0000;
  reg [9:0] EVEN_BUS_IN = 10'h000, ODD_BUS_IN = 10'h000;
  reg [2:0] req = 3'h0;
  wire FRAME_BEGIN_IN, ROW_ADVANCE_IN, SNAP_BEGIN_IN, SNAP_END_IN;
  wire PIX_VALID_OUT, ROLLING_MODE_OUT, CAL_ACTIVE_OUT, CAL_SLOW_OUT;
  wire COL_SHIFT_CLK_OUT, ROW_WINDOW_OUT, FINAL_ROW_OUT, EXPOSURE_DONE_OUT;
  wire READ_SYNC_OUT, RESET_SYNC_OUT, RESET_RIGHT_OUT, CONT_CHARGE_OUT;
  wire EXT_VDDR_OUT, TEST_EVEN_OUT, TEST_ODD_OUT, AMP_UNITY_OUT;
  wire AMP_DUAL_OUT, AMP_STANDBY_OUT;
  wire [9:0] PIX_DATA_OUT;
  wire [10:0] READ_ROW_OUT, RESET_ROW_OUT, COL_ADDR_OUT;
  wire [1:0] KNEE_LEVEL_OUT;
  wire [2:0] COL_SUB_OUT, ROW_SUB_OUT;
  wire [3:0] AMP_GAIN_OUT;
  int failures = 0, n_checks = 0, n_rd = 0, n_rst = 0, n_fin = 0;
  int i, k, j, t, n, b, p;
  reg [31:0] seed = 32'h049f_694c, r;
  reg [11:0] s = 12'h000, a = 12'h000, m = 12'h000;
  reg [9:0] ev, od, ys;
  // decoded register outputs in one vector
  wire [20:0] obs = {ROLLING_MODE_OUT, RESET_RIGHT_OUT, KNEE_LEVEL_OUT,
    CONT_CHARGE_OUT, EXT_VDDR_OUT, TEST_EVEN_OUT, TEST_ODD_OUT, COL_SUB_OUT,
    ROW_SUB_OUT, AMP_GAIN_OUT, AMP_UNITY_OUT, AMP_DUAL_OUT, AMP_STANDBY_OUT};

  image_sensor_readout_sequencer dut (.*);
  timing_ctrl_model ctrl (.clk_in(SYS_CLK_IN), .rst_n_in(RESET_N_IN),
    .req_in(req), .done_in(EXPOSURE_DONE_OUT), .frame_out(FRAME_BEGIN_IN),
    .row_out(ROW_ADVANCE_IN), .snap_begin_out(SNAP_BEGIN_IN),
    .snap_end_out(SNAP_END_IN));

  always #20 SYS_CLK_IN = ~SYS_CLK_IN;
  // pulse tally, sampled mid-cycle
  always @(negedge SYS_CLK_IN) begin
    n_rd  += (READ_SYNC_OUT === 1'b1);
    n_rst += (RESET_SYNC_OUT === 1'b1);
    n_fin += (FINAL_ROW_OUT === 1'b1);
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected decode from shadow registers
  function logic [20:0] dec(input [11:0] s, a, m);
    dec = {s[0], s[10], s[10] ? s[9:8] : 2'h0, s[3], s[11], a[0], a[1],
      a[4:2], a[7:5], m[4] ? 4'h0 : m[3:0], m[4], m[5] & m[6], !m[6]};
  endfunction
  task results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task chk_rng(input int g, lo, hi);
    n_checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task bound(input int g, lim);
    if (g >= lim) begin
      failures++;
      $display("unexpected at %0t: wait ran out", $time);
      results;
    end
  endtask
  // one word per strobe; shadows follow the select
  task wr(input [15:0] w);
    @(posedge SYS_CLK_IN);
    CFG_WORD_IN <= w;
    CFG_WRITE_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    CFG_WRITE_IN <= 1'b0;
    case (w[15:12])
      4'h0: s = w[11:0];
      4'h7: a = w[11:0];
      4'h8: m = w[11:0];
      default: ;
    endcase
  endtask
  task pulse(input [2:0] q);
    @(posedge SYS_CLK_IN);
    req <= q;
    @(posedge SYS_CLK_IN);
    req <= 3'h0;
  endtask

  initial begin
    repeat (16) @(posedge SYS_CLK_IN);
    RESET_N_IN <= 1'b1;
    @(negedge SYS_CLK_IN) chk(obs, 21'h00_0001);
    // random words, unmapped selects among them
    for (i = 0; i < 40; i++) begin
      r = rnd();
      wr(r[15:0]);
      @(negedge SYS_CLK_IN) chk(obs, dec(s, a, m));
    end
    // global exposure at count 10, every snapshot divider
    wr({4'h3, 12'd10});
    for (i = 0; i < 4; i++) begin
      wr({8'h00, i[1:0], 6'h00});
      pulse(3'b100);
      p = 32 << i;
      t = 0;
      do begin @(negedge SYS_CLK_IN); t++; end
      while (EXPOSURE_DONE_OUT !== 1'b1 && t < 3000);
      bound(t, 3000);
      chk_rng(t, 10 * p - 2, 11 * p + 4);
      t = 0;
      do begin @(negedge SYS_CLK_IN); t++; end
      while (EXPOSURE_DONE_OUT !== 1'b0 && t < 300);
      bound(t, 300);
    end
    // rolling frame, restarted after five rows
    r = rnd();
    ys = r[9:0];
    wr({6'h14, ys});
    wr({6'h18, ys});
    wr({6'h10, 1'b0, ys[8:0]});
    wr({4'h1, 12'd3});
    wr({4'h2, 12'd9});
    wr({4'h3, 12'd10});
    for (k = 1; k <= 15; k++) begin
      j = (k <= 5) ? k : k - 5;
      r = rnd();
      wr({10'h000, r[21:20], 4'h3});
      p = 4 << r[21:20];
      if (j == 1) begin
        pulse(3'b001);
        repeat (3) @(negedge SYS_CLK_IN);
        chk(READ_ROW_OUT, {1'b0, ys});
      end
      @(posedge SYS_CLK_IN);
      ev = r[9:0];
      od = r[19:10];
      EVEN_BUS_IN <= ev;
      ODD_BUS_IN <= od;
      pulse(3'b010);
      repeat (2) @(negedge SYS_CLK_IN);
      chk({CAL_ACTIVE_OUT, CAL_SLOW_OUT}, {1'b1, j == 1});
      b = 0;
      n = 0;
      t = 0;
      while ((n < 8 || ROW_WINDOW_OUT) && t < 600) begin
        @(negedge SYS_CLK_IN);
        t++;
        b += (n == 0 && !ROW_WINDOW_OUT && !PIX_VALID_OUT);
        if (PIX_VALID_OUT && PIX_READY_IN) begin
          chk(PIX_DATA_OUT, n[0] ? od : ev);
          n++;
        end
        @(posedge SYS_CLK_IN);
        PIX_READY_IN <= (rnd() % 3 != 0);
      end
      bound(t, 600);
      chk_rng(b, p - 2, p + 3);
      @(negedge SYS_CLK_IN) chk(PIX_VALID_OUT, 1'b0);
      chk(READ_ROW_OUT, {1'b0, ys} + j);
      // four pairs read, start forced even while sub-sampling
      chk(COL_ADDR_OUT, {2'b00, ys[8:1], ys[0] & !a[2]} + 11'd4);
      if (j == 10) chk(RESET_ROW_OUT, {1'b0, ys});
    end
    chk(n_rd, 2);
    chk(n_rst, 1);
    chk(n_fin, 1);
    results;
  end
endmodule
